// ==== pkg/ttc_pkg.sv ====
// shared constants and types of the triggered timer / event counter
// How it works
// R01: trigger mode idles until selected input edge, then counts source clocks
// R02: trigger mode: count equal to limit clears, halts and raises match pulse
// R03: with trigger-stop, opposite edge before match clears and halts silently
// R04: with trigger-stop, halted counter restarts from zero on next trigger
// R05: without trigger-stop, opposite edge and early retrigger are ignored
// R06: input pulses of four clock periods or less never make an edge
// R07: source holds each input level at least twelve clock periods
// R08: event mode counts selected input edges instead of internal clocks
// R09: event mode checks limit at opposite edge, then pulses match and clears
// R10: source keeps event pulse high and low phases two machine cycles
// R11: auto-capture copies running count into capture on each source clock
// R12: software waits one source clock after enabling auto-capture to read
// R13: software reads auto-captured value only while running and enabled
// R14: window mode counts source clocks while input sits at chosen level
// R15: window mode: count equal to limit raises match pulse and clears
// R16: window pulse should be much slower than the source clock
// R17: single-edge width: opposite edge captures, pulses, sets count to one, awaits start
// R18: double-edge: opposite edge captures; start edge captures, clears, goes on
// R19: software picks rising start for high widths, falling for low
// R20: software reads capture before the next start edge, as one word
// R21: after single-edge capture counter rests at one until next edge
// R22: software discards the first capture after starting width measurement
// R23: limit takes low then high byte; applied at next source clock (while stopped, the code applies it on the next clock)
// R24: software changes mode and clock fields only while stopped
// R25: counter, limit and capture are whole 16-bit words
`default_nettype none
package ttc_pkg;
	localparam int CLK_PERIOD_NS = 10;
	localparam int NOISE_NS      = 40;
	localparam int DETECT_NS     = 120;
	localparam int NOISE_CYC     = NOISE_NS / CLK_PERIOD_NS;
	localparam int DETECT_CYC    =
		(DETECT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	// stable run needed is twice the noise limit, within the detect bound
	localparam int FILT_CYC      = NOISE_CYC * 2;
	localparam logic [3:0] FILT_LAST = 4'(FILT_CYC - 1);

	localparam logic [3:0] SHIFT_SLOW = 4'hb;
	localparam logic [3:0] SHIFT_MID  = 4'h7;
	localparam logic [3:0] SHIFT_FAST = 4'h3;

	localparam logic [3:0] ADDR_CTRL     = 4'h0;
	localparam logic [3:0] ADDR_GEAR     = 4'h1;
	localparam logic [3:0] ADDR_LIMIT_LO = 4'h2;
	localparam logic [3:0] ADDR_LIMIT_HI = 4'h3;
	localparam logic [3:0] ADDR_CAP_LO   = 4'h4;
	localparam logic [3:0] ADDR_CAP_HI   = 4'h5;
	localparam logic [3:0] ADDR_CNT_LO   = 4'h6;
	localparam logic [3:0] ADDR_CNT_HI   = 4'h7;

	localparam int CTRL_MODE_LSB = 0;
	localparam int CTRL_CK_LSB   = 2;
	localparam int CTRL_RUN_LSB  = 4;
	localparam int CTRL_OPT_BIT  = 6;

	localparam logic [7:0]  CTRL_RST  = 8'h00;
	localparam logic        GEAR_RST  = 1'b0;
	localparam logic [15:0] LIMIT_RST = 16'hffff;
	localparam logic [15:0] CAP_RST   = 16'h0000;

	localparam logic [1:0] RUN_STOP = 2'h0;
	localparam logic [1:0] RUN_CMD  = 2'h1;
	localparam logic [1:0] RUN_FALL = 2'h3;
	localparam logic [1:0] MODE_TIMER  = 2'h0;
	localparam logic [1:0] MODE_WINDOW = 2'h1;
	localparam logic [1:0] MODE_PULSE  = 2'h2;
	localparam logic [1:0] MODE_PPG    = 2'h3;
	localparam logic [1:0] CK_EXT      = 2'h3;

	typedef enum logic [2:0] {
		ST_STOP  = 3'b001,
		ST_WAIT  = 3'b010,
		ST_COUNT = 3'b100
	} ttc_state_t;
endpackage
`default_nettype wire

// ==== core/ttc_noise_filter.sv ====
// input noise rejection with edge pulses
`default_nettype none
module ttc_noise_filter (
	input  wire logic clk,
	input  wire logic rst,
	input  wire logic ce,
	input  wire logic pin_in,
	output logic      level,
	output logic      rise,
	output logic      fall
);
	logic [3:0] run_reg;
	logic       lvl_reg;
	wire        differ = pin_in != lvl_reg;
	wire        flip   = differ && run_reg == ttc_pkg::FILT_LAST;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			run_reg <= 4'h0;
			lvl_reg <= 1'b0;
			rise    <= 1'b0;
			fall    <= 1'b0;
		end else if (ce) begin
			run_reg <= (differ && !flip) ? run_reg + 4'h1 : 4'h0; // R06
			lvl_reg <= flip ? pin_in : lvl_reg; // R06
			rise    <= flip && pin_in;
			fall    <= flip && !pin_in;
		end
	end

	assign level = lvl_reg;
endmodule // ttc_noise_filter
`default_nettype wire

// ==== core/ttc_prescaler.sv ====
// source clock prescaler giving one-cycle ticks
`default_nettype none
module ttc_prescaler (
	input  wire logic       clk,
	input  wire logic       rst,
	input  wire logic       ce,
	input  wire logic [1:0] ck_sel,
	input  wire logic       div_sel,
	output logic            tick
);
	logic [12:0] div_reg;
	logic [3:0]  base;
	logic [12:0] mask;

	assign base = (ck_sel == 2'h0) ? ttc_pkg::SHIFT_SLOW :
		(ck_sel == 2'h1) ? ttc_pkg::SHIFT_MID : ttc_pkg::SHIFT_FAST;
	assign mask = 13'((13'h1 << (base + 4'(div_sel))) - 13'h1);

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			div_reg <= 13'h0000;
			tick    <= 1'b0;
		end else if (ce) begin
			div_reg <= div_reg + 13'h1;
			tick    <= &(div_reg | ~mask);
		end
	end
endmodule // ttc_prescaler
`default_nettype wire

// ==== core/ttc_timer.sv ====
// triggered timer / event counter with limit and capture registers
//
// The register offsets and strobed register access were decided locally.
`default_nettype none
module ttc_timer (
	input  wire logic       clk,
	input  wire logic       rst,
	input  wire logic       ce,
	input  wire logic [3:0] addr,
	input  wire logic [7:0] wdata,
	input  wire logic       wr,
	input  wire logic       rd,
	output logic      [7:0] rdata,
	input  wire logic       counter_input_pin,
	output logic            timer_match_irq
);
	logic [7:0]         timer_one_control;
	logic               prescaler_divide_select;
	logic [15:0]        compare_limit_register;
	logic [15:0]        capture_register;
	logic [15:0]        cnt_reg;
	logic [15:0]        cnt_next;
	logic [15:0]        cap_next;
	logic [7:0]         lim_lo_reg;
	logic [15:0]        lim_pend_reg;
	logic               pend_reg;
	ttc_pkg::ttc_state_t st_reg;
	ttc_pkg::ttc_state_t st_next;
	logic               irq_next;
	logic               pin_lvl;
	logic               pin_rise;
	logic               pin_fall;
	logic               pre_tick;

	function automatic logic [15:0] inc16(input logic [15:0] v);
		inc16 = v + 16'h0001;
	endfunction

	ttc_noise_filter u_filter (
		.clk    (clk),
		.rst    (rst),
		.ce     (ce),
		.pin_in (counter_input_pin),
		.level  (pin_lvl),
		.rise   (pin_rise),
		.fall   (pin_fall)
	);

	wire [1:0] mode              =
		timer_one_control[ttc_pkg::CTRL_MODE_LSB +: 2];
	wire [1:0] source_clock_select =
		timer_one_control[ttc_pkg::CTRL_CK_LSB +: 2];
	wire [1:0] run_start_select  =
		timer_one_control[ttc_pkg::CTRL_RUN_LSB +: 2];
	wire       opt_bit           = timer_one_control[ttc_pkg::CTRL_OPT_BIT];

	ttc_prescaler u_prescaler (
		.clk     (clk),
		.rst     (rst),
		.ce      (ce),
		.ck_sel  (source_clock_select),
		.div_sel (prescaler_divide_select),
		.tick    (pre_tick)
	);

	// opt_bit is trigger_stop_enable, capture_edge_mode or
	// auto_capture_enable depending on the mode
	wire ext_ck     = source_clock_select == ttc_pkg::CK_EXT;
	wire fall_sel   = run_start_select == ttc_pkg::RUN_FALL;
	wire start_edge = fall_sel ? pin_fall : pin_rise;
	wire opp_edge   = fall_sel ? pin_rise : pin_fall;
	wire stopped    = run_start_select == ttc_pkg::RUN_STOP;
	wire timer_fam  = mode == ttc_pkg::MODE_TIMER;
	wire is_event   = timer_fam && ext_ck;
	wire is_trig    = timer_fam && !ext_ck && run_start_select[1];
	wire is_cmd     = timer_fam && !ext_ck &&
		run_start_select == ttc_pkg::RUN_CMD;
	wire is_win     = mode == ttc_pkg::MODE_WINDOW;
	wire is_pw      = mode == ttc_pkg::MODE_PULSE;
	wire src_clk    = ext_ck ? start_edge : pre_tick;
	wire gate_lvl   = fall_sel ? !pin_lvl : pin_lvl;
	wire at_limit   = cnt_reg == compare_limit_register; // R25
	wire auto_cap   = opt_bit && (is_cmd || is_event || is_win);
	wire armed_mode = is_trig || is_pw;
	wire counting   = st_reg == ttc_pkg::ST_COUNT;
	wire wr_ctrl    = wr && addr == ttc_pkg::ADDR_CTRL;
	wire wr_gear    = wr && addr == ttc_pkg::ADDR_GEAR;
	wire wr_lim_lo  = wr && addr == ttc_pkg::ADDR_LIMIT_LO;
	wire wr_lim_hi  = wr && addr == ttc_pkg::ADDR_LIMIT_HI;
	wire lim_apply  = pend_reg && (src_clk || stopped); // R23

	always_comb begin
		st_next  = st_reg;
		cnt_next = cnt_reg;
		cap_next = capture_register;
		irq_next = 1'b0;
		if (stopped || mode == ttc_pkg::MODE_PPG) begin
			st_next  = ttc_pkg::ST_STOP;
			cnt_next = 16'h0000;
		end else begin
			case (st_reg)
			ttc_pkg::ST_STOP: begin
				st_next  = armed_mode ? ttc_pkg::ST_WAIT : ttc_pkg::ST_COUNT;
				cnt_next = 16'h0000;
			end
			ttc_pkg::ST_WAIT: begin
				if (start_edge || !armed_mode) begin
					st_next = ttc_pkg::ST_COUNT; // R01 R04
				end
			end
			ttc_pkg::ST_COUNT: begin
				if (is_event) begin
					if (start_edge) begin
						cnt_next = inc16(cnt_reg); // R08
					end else if (opp_edge && at_limit) begin
						cnt_next = 16'h0000; // R09
						irq_next = 1'b1; // R09
					end
				end else if (is_pw) begin
					if (opp_edge) begin
						cap_next = cnt_reg; // R17 R18
						irq_next = 1'b1; // R17 R18
						if (opt_bit) begin
							cnt_next = 16'h0001; // R21
							st_next  = ttc_pkg::ST_WAIT; // R17
						end else if (src_clk) begin
							cnt_next = inc16(cnt_reg);
						end
					end else if (start_edge && !opt_bit) begin
						cap_next = cnt_reg; // R18
						irq_next = 1'b1; // R18
						cnt_next = 16'h0000; // R18
					end else if (src_clk) begin
						cnt_next = inc16(cnt_reg);
					end
				end else if (is_trig && opt_bit && opp_edge) begin
					cnt_next = 16'h0000; // R03
					st_next  = ttc_pkg::ST_WAIT; // R03
				end else if (src_clk && (!is_win || gate_lvl)) begin // R14
					if (at_limit) begin
						cnt_next = 16'h0000; // R02 R15
						irq_next = 1'b1; // R02 R15
						if (is_trig) begin
							st_next = ttc_pkg::ST_WAIT; // R02 R05
						end
					end else begin
						cnt_next = inc16(cnt_reg); // R01 R05
					end
				end
			end
			default: st_next = ttc_pkg::ST_STOP;
			endcase
		end
		if (auto_cap && src_clk && counting) begin
			cap_next = cnt_reg; // R11
		end
	end

	wire [7:0] rd_val =
		(addr == ttc_pkg::ADDR_CTRL)     ? timer_one_control :
		(addr == ttc_pkg::ADDR_GEAR)     ? {7'h00, prescaler_divide_select} :
		(addr == ttc_pkg::ADDR_LIMIT_LO) ? compare_limit_register[7:0] :
		(addr == ttc_pkg::ADDR_LIMIT_HI) ? compare_limit_register[15:8] :
		(addr == ttc_pkg::ADDR_CAP_LO)   ? capture_register[7:0] :
		(addr == ttc_pkg::ADDR_CAP_HI)   ? capture_register[15:8] :
		(addr == ttc_pkg::ADDR_CNT_LO)   ? cnt_reg[7:0] :
		(addr == ttc_pkg::ADDR_CNT_HI)   ? cnt_reg[15:8] : 8'h00;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			timer_one_control       <= ttc_pkg::CTRL_RST;
			prescaler_divide_select <= ttc_pkg::GEAR_RST;
			rdata                   <= 8'h00;
		end else if (ce) begin
			if (wr_ctrl) begin
				timer_one_control <= wdata;
			end
			if (wr_gear) begin
				prescaler_divide_select <= wdata[0];
			end
			rdata <= rd ? rd_val : 8'h00;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			lim_lo_reg             <= 8'h00;
			lim_pend_reg           <= ttc_pkg::LIMIT_RST;
			pend_reg               <= 1'b0;
			compare_limit_register <= ttc_pkg::LIMIT_RST;
		end else if (ce) begin
			if (wr_lim_lo) begin
				lim_lo_reg <= wdata; // R23
			end
			if (wr_lim_hi) begin
				lim_pend_reg <= {wdata, lim_lo_reg}; // R23 R25
			end
			pend_reg <= wr_lim_hi || (pend_reg && !lim_apply);
			if (lim_apply) begin
				compare_limit_register <= lim_pend_reg; // R23
			end
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			st_reg           <= ttc_pkg::ST_STOP;
			cnt_reg          <= 16'h0000;
			capture_register <= ttc_pkg::CAP_RST;
			timer_match_irq  <= 1'b0;
		end else if (ce) begin
			st_reg           <= st_next;
			cnt_reg          <= cnt_next;
			capture_register <= cap_next; // R25
			timer_match_irq  <= irq_next;
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	wire quiet = ce && !wr;
	wire live  = quiet && !stopped;
	chk_trig_idle: assert property ( // R01
		quiet && is_trig && st_reg == ttc_pkg::ST_WAIT
		|=> cnt_reg == 16'h0000)
		else $error("trigger mode counted before its start edge");
	chk_trig_match: assert property ( // R02
		quiet && is_trig && counting && src_clk && at_limit &&
		!(opt_bit && opp_edge)
		|=> timer_match_irq && cnt_reg == 16'h0000 &&
		st_reg == ttc_pkg::ST_WAIT)
		else $error("trigger match did not clear, halt and pulse");
	chk_trig_abort: assert property ( // R03
		quiet && is_trig && opt_bit && counting && opp_edge
		|=> !timer_match_irq && cnt_reg == 16'h0000 &&
		st_reg == ttc_pkg::ST_WAIT)
		else $error("opposite edge did not halt silently");
	chk_trig_restart: assert property ( // R04
		quiet && is_trig && st_reg == ttc_pkg::ST_WAIT && start_edge
		|=> counting ##1 cnt_reg <= 16'h0001)
		else $error("trigger restart did not begin from zero");
	chk_event_count: assert property ( // R08
		quiet && is_event && counting && start_edge
		|=> cnt_reg == 16'($past(cnt_reg) + 16'h0001))
		else $error("event edge did not advance the counter");
	chk_event_match: assert property ( // R09
		quiet && is_event && counting && opp_edge && at_limit
		|=> timer_match_irq && cnt_reg == 16'h0000)
		else $error("event match missing at opposite edge");
	chk_window_gate: assert property ( // R14
		quiet && is_win && counting && !gate_lvl |=> $stable(cnt_reg))
		else $error("window counter moved while gate closed");
	chk_pulse_single: assert property ( // R17
		quiet && is_pw && opt_bit && counting && opp_edge
		|=> capture_register == $past(cnt_reg) &&
		cnt_reg == 16'h0001 && timer_match_irq)
		else $error("single-edge capture wrong");
	chk_pulse_double: assert property ( // R18
		quiet && is_pw && !opt_bit && counting && start_edge
		|=> capture_register == $past(cnt_reg) &&
		cnt_reg == 16'h0000 && timer_match_irq)
		else $error("double-edge restart capture wrong");
	chk_auto_capture: assert property ( // R11
		quiet && auto_cap && counting && src_clk && !is_pw
		|=> capture_register == $past(cnt_reg))
		else $error("auto-capture missed a source clock");
	chk_limit_hold: assert property ( // R23
		ce && !pend_reg |=> $stable(compare_limit_register))
		else $error("limit changed without a high byte write");

	chk_trig_ignore: assert property ( // R05
		live && is_trig && !opt_bit && counting && !src_clk &&
		(start_edge || opp_edge) |=> counting && $stable(cnt_reg))
		else $error("input edge disturbed a trigger count");
	chk_trig_rearm: assert property ( // R04
		live && is_trig && opt_bit && st_reg == ttc_pkg::ST_WAIT &&
		!start_edge |=> st_reg == ttc_pkg::ST_WAIT)
		else $error("halted trigger counter left idle without an edge");
	chk_event_hold: assert property ( // R08
		live && is_event && counting && !start_edge && !opp_edge
		|=> $stable(cnt_reg))
		else $error("event counter moved without an input edge");
	chk_window_count: assert property ( // R14
		live && is_win && counting && src_clk && gate_lvl && !at_limit
		|=> cnt_reg == 16'($past(cnt_reg) + 16'h0001))
		else $error("window counter missed an open source clock");
	chk_window_match: assert property ( // R15
		live && is_win && counting && src_clk && gate_lvl && at_limit
		|=> timer_match_irq && cnt_reg == 16'h0000)
		else $error("window match did not clear and pulse");
	chk_pulse_open: assert property ( // R18
		live && is_pw && !opt_bit && counting && opp_edge
		|=> capture_register == $past(cnt_reg) && timer_match_irq &&
		counting)
		else $error("double-edge opposite capture wrong");
	chk_pulse_rest: assert property ( // R21
		live && is_pw && opt_bit && st_reg == ttc_pkg::ST_WAIT &&
		!start_edge |=> $stable(cnt_reg))
		else $error("single-edge counter left its rest value");
	chk_cap_hold: assert property ( // R11
		live && !auto_cap && !is_pw |=> $stable(capture_register))
		else $error("capture changed with no capture source");
	chk_limit_apply: assert property ( // R23
		ce && lim_apply
		|=> compare_limit_register == $past(lim_pend_reg))
		else $error("pending limit word not applied whole");

	cov_trig_match: cover property (is_trig && timer_match_irq);
	cov_event_match: cover property (is_event && timer_match_irq);
	cov_pulse_cap: cover property (is_pw && timer_match_irq);
	cov_window_match: cover property (is_win && timer_match_irq);
	cov_pulse_double: cover property (is_pw && !opt_bit && timer_match_irq);
endmodule // ttc_timer
`default_nettype wire

// ==== testbench/ttc_pulse_src.sv ====
// pulse source model driving the counter input pin
`default_nettype none
module ttc_pulse_src (
	input  wire logic clk,
	output logic      pin
);
	timeunit 1ns;
	timeprecision 1ps;
	localparam int HOLD_MIN = 12;

	initial pin = 1'b0;

	// hold a level, never shorter than the guaranteed detect span
	task automatic hold(input logic lvl, input int cyc);
		int n;
		n = (cyc < HOLD_MIN) ? HOLD_MIN : cyc;
		@(posedge clk);
		pin <= lvl;
		repeat (n - 1) @(posedge clk);
	endtask

	// deliberate short glitch that the input filter has to drop
	task automatic glitch(input int cyc);
		@(posedge clk);
		pin <= ~pin;
		repeat (cyc) @(posedge clk);
		pin <= ~pin;
	endtask
endmodule // ttc_pulse_src
`default_nettype wire

// ==== testbench/ttc_timer_tb.sv ====
// self-checking bench for the triggered timer and event counter
`default_nettype none
`define CHK(nm, ex, got) begin n_checks++; if ((got) !== (ex)) begin \
	bad_count++; $display("mismatch %s exp %0h got %0h", nm, ex, got); \
	end end
module ttc_timer_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clk;
	logic        rst;
	logic        ce;
	logic        wr;
	logic        rd;
	logic        irq;
	logic [3:0]  addr;
	logic [7:0]  wdata;
	logic [7:0]  rdata;
	wire logic   pin;
	int          bad_count;
	int          n_checks;
	int          irq_n;
	int          i0;
	logic [15:0] v;
	logic [15:0] w;

	ttc_timer ttc_timer_inst (
		.clk              (clk),
		.rst              (rst),
		.ce               (ce),
		.addr             (addr),
		.wdata            (wdata),
		.wr               (wr),
		.rd               (rd),
		.rdata            (rdata),
		.counter_input_pin(pin),
		.timer_match_irq  (irq)
	);
	ttc_pulse_src ttc_pulse_src_inst (
		.clk(clk),
		.pin(pin)
	);

	always #(ttc_pkg::CLK_PERIOD_NS / 2) clk = ~clk;
	// match pulses counted away from the launching edge
	always @(negedge clk) if (irq === 1'b1) irq_n++;

	task automatic wreg(input logic [3:0] a, input logic [7:0] d);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
		@(posedge clk);
	endtask

	task automatic rd16(input logic [3:0] a, output logic [15:0] d);
		for (int k = 0; k < 2; k++) begin
			addr <= a + 4'(k);
			rd <= 1'b1;
			@(posedge clk);
			rd <= 1'b0;
			#1 d[8*k +: 8] = rdata;
			@(posedge clk);
		end
	endtask

	task automatic cfg(input logic [7:0] c, input logic [15:0] l);
		wreg(ttc_pkg::ADDR_CTRL, ttc_pkg::CTRL_RST);
		wreg(ttc_pkg::ADDR_LIMIT_LO, l[7:0]);
		wreg(ttc_pkg::ADDR_LIMIT_HI, l[15:8]);
		wreg(ttc_pkg::ADDR_CTRL, c);
	endtask

	task automatic t_regs();
		rd16(ttc_pkg::ADDR_LIMIT_LO, v);
		`CHK("lim_rst", ttc_pkg::LIMIT_RST, v)
		rd16(ttc_pkg::ADDR_CAP_LO, v);
		`CHK("cap_rst", ttc_pkg::CAP_RST, v)
		wreg(4'h8, 8'h5a);
		rd16(4'h8, v);
		`CHK("unmapped", 16'h0000, v)
		wreg(ttc_pkg::ADDR_LIMIT_LO, 8'h05);
		rd16(ttc_pkg::ADDR_LIMIT_LO, v);
		`CHK("lim_lo_only", 16'hffff, v)
		wreg(ttc_pkg::ADDR_LIMIT_HI, 8'h00);
		rd16(ttc_pkg::ADDR_LIMIT_LO, v);
		`CHK("lim_word", 16'h0005, v)
	endtask

	task automatic t_event();
		cfg(8'h2c, 16'h0003);
		i0 = irq_n;
		repeat (2) begin
			ttc_pulse_src_inst.hold(1'b1, 12);
			ttc_pulse_src_inst.hold(1'b0, 12);
		end
		ttc_pulse_src_inst.glitch(4);
		ttc_pulse_src_inst.hold(1'b0, 12);
		rd16(ttc_pkg::ADDR_CNT_LO, v);
		`CHK("evt_cnt", 16'h0002, v)
		ttc_pulse_src_inst.hold(1'b1, 12);
		`CHK("evt_early", i0, irq_n)
		ttc_pulse_src_inst.hold(1'b0, 12);
		`CHK("evt_irq", i0 + 1, irq_n)
		rd16(ttc_pkg::ADDR_CNT_LO, v);
		`CHK("evt_clr", 16'h0000, v)
	endtask

	task automatic t_trig(input logic [7:0] c, input int exp_n);
		cfg(c, 16'h0006);
		i0 = irq_n;
		repeat (60) @(posedge clk);
		rd16(ttc_pkg::ADDR_CNT_LO, v);
		`CHK("trg_idle", 16'h0000, v)
		ttc_pulse_src_inst.hold(1'b1, 30);
		ttc_pulse_src_inst.hold(1'b0, 60);
		`CHK("trg_opp", i0 + exp_n, irq_n)
		rd16(ttc_pkg::ADDR_CNT_LO, v);
		`CHK("trg_halt", 16'h0000, v)
		ttc_pulse_src_inst.hold(1'b1, 100);
		`CHK("trg_match", i0 + exp_n + 1, irq_n)
		rd16(ttc_pkg::ADDR_CNT_LO, v);
		`CHK("trg_stop", 16'h0000, v)
		ttc_pulse_src_inst.hold(1'b0, 30);
	endtask

	task automatic t_pulse();
		cfg(8'h6a, 16'hffff);
		i0 = irq_n;
		ttc_pulse_src_inst.hold(1'b1, 60);
		ttc_pulse_src_inst.hold(1'b0, 30);
		`CHK("pw_irq", i0 + 1, irq_n)
		rd16(ttc_pkg::ADDR_CNT_LO, v);
		`CHK("pw_rest", 16'h0001, v)
		rd16(ttc_pkg::ADDR_CAP_LO, v);
		`CHK("pw_cap", 1'b1, v > 16'h0004 && v < 16'h0009)
		ttc_pulse_src_inst.hold(1'b1, 60);
		ttc_pulse_src_inst.hold(1'b0, 30);
		`CHK("pw_irq2", i0 + 2, irq_n)
		rd16(ttc_pkg::ADDR_CAP_LO, v);
		`CHK("pw_cap2", 1'b1, v > 16'h0007 && v < 16'h000a)
	endtask

	task automatic t_pulse2();
		cfg(8'h3a, 16'hffff);
		i0 = irq_n;
		ttc_pulse_src_inst.hold(1'b1, 30);
		ttc_pulse_src_inst.hold(1'b0, 40);
		`CHK("pw2_wait", i0, irq_n)
		ttc_pulse_src_inst.hold(1'b1, 40);
		`CHK("pw2_open", i0 + 1, irq_n)
		ttc_pulse_src_inst.hold(1'b0, 20);
		`CHK("pw2_irq", i0 + 2, irq_n)
		rd16(ttc_pkg::ADDR_CAP_LO, v);
		`CHK("pw2_cap", 1'b1, v > 16'h0008 && v < 16'h000b)
	endtask

	task automatic t_window();
		cfg(8'h29, 16'h0002);
		i0 = irq_n;
		repeat (100) @(posedge clk);
		rd16(ttc_pkg::ADDR_CNT_LO, v);
		`CHK("win_closed", 16'h0000, v)
		ttc_pulse_src_inst.hold(1'b1, 120);
		`CHK("win_irq", 1'b1, irq_n >= i0 + 3 && irq_n <= i0 + 6)
		ttc_pulse_src_inst.hold(1'b0, 12);
		rd16(ttc_pkg::ADDR_CNT_LO, w);
		repeat (50) @(posedge clk);
		rd16(ttc_pkg::ADDR_CNT_LO, v);
		`CHK("win_gate", w, v)
	endtask

	task automatic t_autocap();
		cfg(8'h58, 16'hffff);
		repeat (100) @(posedge clk);
		rd16(ttc_pkg::ADDR_CAP_LO, v);
		`CHK("acap", 1'b1, v > 16'h0008 && v < 16'h0010)
		ce <= 1'b0;
		repeat (200) @(posedge clk);
		ce <= 1'b1;
		rd16(ttc_pkg::ADDR_CAP_LO, w);
		`CHK("acap_freeze", 1'b1, w - v < 16'h0003)
	endtask

	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	initial begin
		clk = 1'b0;
		rst = 1'b1;
		ce = 1'b1;
		wr = 1'b0;
		rd = 1'b0;
		addr = 4'h0;
		wdata = 8'h00;
		repeat (16) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		t_regs();
		t_event();
		t_trig(8'h68, 0);
		t_trig(8'h28, 1);
		t_pulse();
		t_pulse2();
		t_window();
		t_autocap();
		tally_and_finish();
	end

	initial begin
		repeat (20000) @(posedge clk);
		bad_count++;
		tally_and_finish();
	end
endmodule // ttc_timer_tb
`default_nettype wire
